// file: logic/clock_mode_pkg.sv
/*
 package of constants for the system clock and operating mode control block.
 assumes an axi4-lite register bus with 32-bit data on aclk.
*/
package clock_mode_pkg;
   localparam logic [3:0] mode_ctrl_offset   = 4'h0;
   localparam logic [3:0] mode_ctrl2_offset  = 4'h4;
   localparam logic [3:0] status_offset      = 4'h8;
   localparam int         div_sel_lsb        = 5;
   localparam int         slow_ready_bit     = 3;
   localparam int         fast_ready_bit     = 2;
   localparam int         idle_enable_bit    = 1;
   localparam int         fast_slow_bit      = 0;
   localparam int         keep_sysclk_bit    = 7;
   localparam int         reserved_three_bit = 3;
   localparam int         lvr_flag_bit       = 2;
   localparam int         wdt_soft_flag_bit  = 0;
   localparam logic [2:0] div_sel_reset      = 3'h0;
   localparam logic       idle_enable_reset  = 1'b1;
   localparam logic       fast_slow_reset    = 1'b1;
   localparam logic       keep_sysclk_reset  = 1'b0;
   localparam int         fast_stable_cycles = 16;
   localparam int         slow_ready_cycles  = 2;
   localparam int         max_div_log2       = 6;

   typedef enum logic [2:0]
   {
      run_fast            = 3'b000,
      run_slow            = 3'b001,
      doze_sysclk_stopped = 3'b010,
      doze_sysclk_running = 3'b011,
      deep_stop_all       = 3'b100,
      deep_stop_wdt_alive = 3'b101
   } op_mode_type;
endpackage : clock_mode_pkg

// file: logic/osc_ready_timer.sv
/*
 ready flag for one oscillator: counts stable cycles while enabled.
 assumes enable comes from logic on aclk.
*/
module osc_ready_timer
#(
   parameter int cycles = 16
)
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic enable,
   output logic      ready
);
   logic [7:0] count_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn || !enable)
      begin
         count_reg <= 8'h00;
         ready     <= 1'b0;
      end
      else if (count_reg >= 8'(cycles - 1))
         ready <= 1'b1;
      else
         count_reg <= count_reg + 8'h01;
   end
endmodule : osc_ready_timer

// file: logic/clock_select_mux.sv
/*
 glitch-free select of the system clock enable pulse between two sources.
 assumes source pulses come from logic on aclk.
*/
module clock_select_mux
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic want_slow,
   input  wire logic fast_tick,
   input  wire logic slow_tick,
   input  wire logic fast_ok,
   input  wire logic slow_ok,
   output logic      use_slow,
   output logic      sys_tick
);
   logic fast_on_reg;
   logic slow_on_reg;

   // break before make, new source held until ready
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fast_on_reg <= 1'b0;
         slow_on_reg <= 1'b0;
      end
      else
      begin
         fast_on_reg <= !want_slow && !slow_on_reg && fast_ok;
         slow_on_reg <= want_slow && !fast_on_reg && slow_ok;
      end
   end

   assign use_slow = slow_on_reg;
   assign sys_tick = (fast_on_reg && fast_tick) || (slow_on_reg && slow_tick);
endmodule : clock_select_mux

// file: logic/system_clock_mode_control.sv
/*
 system clock and operating mode control with axi4-lite registers.
 assumes halt, wake and watchdog state come from core logic on aclk,
 and fast/slow oscillator ticks are synchronous enable pulses on aclk.
*/
// The AXI4-Lite register port and the register addresses were left to the implementer.
module system_clock_mode_control
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        halt_exec,
   input  wire logic        wake_up,
   input  wire logic        watchdog_enabled,
   input  wire logic        fast_rc_tick,
   input  wire logic        slow_rc_tick,
   output logic             fast_rc_enable,
   output logic             slow_rc_enable,
   output logic             cpu_clock_enable,
   output logic             sys_clock_tick,
   output logic             time_base_enable,
   output logic             watchdog_clock_enable,
   output logic             watchdog_clear,
   output logic             power_down_set,
   output logic             timeout_clear,
   output logic [2:0]       op_mode
);
   logic [2:0]                   div_sel_reg;
   logic                         idle_enable_reg;
   logic                         fast_slow_reg;
   logic                         keep_sysclk_reg;
   logic                         reserved_three_reg;
   logic                         lvr_flag_reg;
   logic                         wdt_soft_flag_reg;
   logic                         power_down_reg;
   clock_mode_pkg::op_mode_type  mode_reg;
   logic [5:0]                   div_count_reg;
   logic                         aw_hold_reg;
   logic                         w_hold_reg;
   logic [3:0]                   aw_addr_reg;
   logic [31:0]                  w_data_reg;
   logic                         w_strb0_reg;
   logic                         want_slow;
   logic                         halted;
   logic                         fast_ready;
   logic                         slow_ready;
   logic                         use_slow;
   logic                         div_tick;
   logic                         mux_tick;
   logic [5:0]                   div_mask;
   logic                         do_write;
   logic [7:0]                   ctrl_byte;
   logic [7:0]                   ctrl2_byte;

   // slow source for select 000 or 001 when the fast/slow bit is 0
   assign want_slow = !fast_slow_reg
      && (div_sel_reg[2:1] == 2'b00);
   assign halted    = (mode_reg != clock_mode_pkg::run_fast)
      && (mode_reg != clock_mode_pkg::run_slow);

   // fast rc off whenever the slow source is chosen or sysclk stopped
   assign fast_rc_enable = !want_slow && !use_slow
      && (mode_reg != clock_mode_pkg::doze_sysclk_stopped)
      && (mode_reg != clock_mode_pkg::deep_stop_all)
      && (mode_reg != clock_mode_pkg::deep_stop_wdt_alive);
   // slow rc stops only in deep stop all
   assign slow_rc_enable = (mode_reg != clock_mode_pkg::deep_stop_all);

   osc_ready_timer
   #(
      .cycles (clock_mode_pkg::fast_stable_cycles)
   )
   fast_timer
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .enable  (fast_rc_enable),
      .ready   (fast_ready)
   );

   osc_ready_timer
   #(
      .cycles (clock_mode_pkg::slow_ready_cycles)
   )
   slow_timer
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .enable  (slow_rc_enable),
      .ready   (slow_ready)
   );

   // divider for fast /2 to /64
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         div_count_reg <= 6'h00;
      else if (fast_rc_tick)
         div_count_reg <= div_count_reg + 6'h01;
   end

   always_comb
   begin
      case (div_sel_reg)
         3'b010:  div_mask = 6'h3f;
         3'b011:  div_mask = 6'h1f;
         3'b100:  div_mask = 6'h0f;
         3'b101:  div_mask = 6'h07;
         3'b110:  div_mask = 6'h03;
         3'b111:  div_mask = 6'h01;
         default: div_mask = 6'h00;
      endcase
      if (fast_slow_reg)
         div_mask = 6'h00;
   end

   assign div_tick = fast_rc_tick
      && ((div_count_reg & div_mask) == div_mask);

   clock_select_mux mux
   (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .want_slow (want_slow),
      .fast_tick (div_tick),
      .slow_tick (slow_rc_tick),
      .fast_ok   (fast_ready),
      .slow_ok   (slow_ready),
      .use_slow  (use_slow),
      .sys_tick  (mux_tick)
   );

   // system clock stops at once in doze stopped and both deep stops
   assign sys_clock_tick = mux_tick
      && (mode_reg != clock_mode_pkg::doze_sysclk_stopped)
      && (mode_reg != clock_mode_pkg::deep_stop_all)
      && (mode_reg != clock_mode_pkg::deep_stop_wdt_alive);

   // operating mode state
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mode_reg <= clock_mode_pkg::run_fast;
      else
      begin
         case (mode_reg)
            clock_mode_pkg::run_fast,
            clock_mode_pkg::run_slow:
            begin
               if (halt_exec)
               begin
                  if (idle_enable_reg)
                     mode_reg <= keep_sysclk_reg
                        ? clock_mode_pkg::doze_sysclk_running
                        : clock_mode_pkg::doze_sysclk_stopped;
                  else
                     mode_reg <= watchdog_enabled
                        ? clock_mode_pkg::deep_stop_wdt_alive
                        : clock_mode_pkg::deep_stop_all;
               end
               else
                  mode_reg <= use_slow ? clock_mode_pkg::run_slow
                     : clock_mode_pkg::run_fast;
            end
            clock_mode_pkg::doze_sysclk_stopped,
            clock_mode_pkg::doze_sysclk_running,
            clock_mode_pkg::deep_stop_all,
            clock_mode_pkg::deep_stop_wdt_alive:
            begin
               if (wake_up)
                  mode_reg <= want_slow ? clock_mode_pkg::run_slow
                     : clock_mode_pkg::run_fast;
            end
            default:
               mode_reg <= clock_mode_pkg::run_fast;
         endcase
      end
   end

   assign op_mode          = mode_reg;
   assign cpu_clock_enable = !halted;
   assign time_base_enable = (mode_reg != clock_mode_pkg::deep_stop_all)
      && (mode_reg != clock_mode_pkg::deep_stop_wdt_alive);
   assign watchdog_clock_enable = slow_rc_enable && watchdog_enabled;

   // halt entry pulses and power-down flag
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         power_down_set <= 1'b0;
         timeout_clear  <= 1'b0;
         watchdog_clear <= 1'b0;
         power_down_reg <= 1'b0;
      end
      else
      begin
         power_down_set <= halt_exec && !halted;
         timeout_clear  <= halt_exec && !halted;
         watchdog_clear <= halt_exec && !halted;
         if (halt_exec && !halted)
            power_down_reg <= 1'b1;
      end
   end

   // axi4-lite write path
   assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
   assign do_write      = aw_hold_reg && w_hold_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_reg  <= 1'b0;
         w_hold_reg   <= 1'b0;
         aw_addr_reg  <= 4'h0;
         w_data_reg   <= 32'h0000_0000;
         w_strb0_reg  <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_reg  <= 1'b1;
            w_data_reg  <= s_axi_wdata;
            w_strb0_reg <= s_axi_wstrb[0];
         end
         if (do_write)
         begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_reg == clock_mode_pkg::mode_ctrl_offset
               || aw_addr_reg == clock_mode_pkg::mode_ctrl2_offset
               || aw_addr_reg == clock_mode_pkg::status_offset)
               ? 2'b00 : 2'b10;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // control register fields
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         div_sel_reg        <= clock_mode_pkg::div_sel_reset;
         idle_enable_reg    <= clock_mode_pkg::idle_enable_reset;
         fast_slow_reg      <= clock_mode_pkg::fast_slow_reset;
         keep_sysclk_reg    <= clock_mode_pkg::keep_sysclk_reset;
         reserved_three_reg <= 1'b0;
         lvr_flag_reg       <= 1'b0;
         wdt_soft_flag_reg  <= 1'b0;
      end
      else if (do_write && w_strb0_reg)
      begin
         if (aw_addr_reg == clock_mode_pkg::mode_ctrl_offset)
         begin
            div_sel_reg <= w_data_reg[clock_mode_pkg::div_sel_lsb +: 3];
            idle_enable_reg <= w_data_reg[clock_mode_pkg::idle_enable_bit];
            fast_slow_reg <= w_data_reg[clock_mode_pkg::fast_slow_bit];
         end
         if (aw_addr_reg == clock_mode_pkg::mode_ctrl2_offset)
         begin
            keep_sysclk_reg <= w_data_reg[clock_mode_pkg::keep_sysclk_bit];
            reserved_three_reg <=
               w_data_reg[clock_mode_pkg::reserved_three_bit];
            lvr_flag_reg <= w_data_reg[clock_mode_pkg::lvr_flag_bit];
            wdt_soft_flag_reg <=
               w_data_reg[clock_mode_pkg::wdt_soft_flag_bit];
         end
      end
   end

   // read-only ready flags, unimplemented bits read 0
   always_comb
   begin
      ctrl_byte = 8'h00;
      ctrl_byte[clock_mode_pkg::div_sel_lsb +: 3]      = div_sel_reg;
      ctrl_byte[clock_mode_pkg::slow_ready_bit]        = slow_ready;
      ctrl_byte[clock_mode_pkg::fast_ready_bit]        = fast_ready;
      ctrl_byte[clock_mode_pkg::idle_enable_bit]       = idle_enable_reg;
      ctrl_byte[clock_mode_pkg::fast_slow_bit]         = fast_slow_reg;
      ctrl2_byte = 8'h00;
      ctrl2_byte[clock_mode_pkg::keep_sysclk_bit]      = keep_sysclk_reg;
      ctrl2_byte[clock_mode_pkg::reserved_three_bit]   = reserved_three_reg;
      ctrl2_byte[clock_mode_pkg::lvr_flag_bit]         = lvr_flag_reg;
      ctrl2_byte[clock_mode_pkg::wdt_soft_flag_bit]    = wdt_soft_flag_reg;
   end

   // axi4-lite read path
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'b00;
         case (s_axi_araddr)
            clock_mode_pkg::mode_ctrl_offset:
               s_axi_rdata <= {24'h00_0000, ctrl_byte};
            clock_mode_pkg::mode_ctrl2_offset:
               s_axi_rdata <= {24'h00_0000, ctrl2_byte};
            clock_mode_pkg::status_offset:
               s_axi_rdata <= {26'h000_0000, use_slow, power_down_reg,
                  1'b0, mode_reg};
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule : system_clock_mode_control

// file: bench/clock_mode_asserts.sv
/*
 port-level checker for system_clock_mode_control.
 assumes the block's aclk and synchronous active-low aresetn.
*/
module clock_mode_asserts
(
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       halt_exec,
   input wire logic [2:0] op_mode,
   input wire logic       cpu_clock_enable,
   input wire logic       power_down_set,
   input wire logic       timeout_clear,
   input wire logic       watchdog_clear,
   input wire logic       slow_rc_enable,
   input wire logic       watchdog_clock_enable,
   input wire logic       sys_clock_tick,
   input wire logic       time_base_enable
);
   default clocking mode_clk @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   run_cpu_clock_a : assert property (
      cpu_clock_enable == (op_mode < 3'h2))
      else $error("cpu clock enable disagrees with mode");
   halt_entry_a : assert property (
      halt_exec && op_mode < 3'h2 |=> op_mode > 3'h1)
      else $error("halt did not enter a halt mode");
   halt_flags_a : assert property (
      halt_exec && op_mode < 3'h2 |=>
      power_down_set && timeout_clear && watchdog_clear)
      else $error("halt flags missing");
   flag_pulse_a : assert property (
      power_down_set |-> $past(halt_exec) ##1 !power_down_set)
      else $error("power down pulse wrong");
   deep_all_a : assert property (
      op_mode == 3'h4 |-> !(slow_rc_enable || watchdog_clock_enable ||
      sys_clock_tick || time_base_enable))
      else $error("deep stop left a clock running");
   deep_wdt_a : assert property (
      op_mode == 3'h5 |-> slow_rc_enable && watchdog_clock_enable &&
      !sys_clock_tick && !time_base_enable)
      else $error("watchdog sleep clocks wrong");
   doze_stop_a : assert property (
      op_mode == 3'h2 |-> !sys_clock_tick && time_base_enable &&
      slow_rc_enable)
      else $error("doze with clock stopped wrong");
   doze_run_a : assert property (
      op_mode == 3'h3 |-> slow_rc_enable && time_base_enable)
      else $error("doze with clock running wrong");
endmodule : clock_mode_asserts

bind system_clock_mode_control clock_mode_asserts chk
(
   .*
);

// file: bench/system_clock_mode_control_tb_top.sv
/*
 testbench for system_clock_mode_control: clock select rows, halt modes,
 reset values and bus refusals.
 assumes the package and design files are compiled before it.
*/
`define check(what, exp, got) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
         miscompares++; \
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
      end \
   end

module system_clock_mode_control_tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct packed {logic [7:0] ctrl; logic [7:0] ticks;} row_type;

   logic        aclk = 1'b0;
   logic        aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, halt_exec, wake_up;
   logic        watchdog_enabled, fast_rc_tick;
   logic        slow_rc_tick = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, fast_rc_enable, slow_rc_enable;
   logic        cpu_clock_enable, sys_clock_tick, time_base_enable;
   logic        watchdog_clock_enable, watchdog_clear, power_down_set;
   logic        timeout_clear, on_slow;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic [1:0]  slow_div = 2'h0;
   logic [2:0]  op_mode, want_mode;
   int          miscompares, comparisons, ticks;
   row_type     rows [9] = '{16'h0180, 16'h0020, 16'h2020, 16'h4002,
                             16'h6004, 16'h8008, 16'hA010, 16'hC020,
                             16'hE040};

   system_clock_mode_control uut
   (
      .*
   );

   always #50 aclk = ~aclk;

   // slow oscillator pulse every fourth cycle
   always @(posedge aclk)
   begin
      slow_div     <= slow_div + 2'h1;
      slow_rc_tick <= (slow_div == 2'h3);
   end

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d,
                         input logic [3:0] s);
      logic done;
      logic ta;
      logic tw;
      done = 1'b0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h00_0000, d};
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!done)
      begin
         @(negedge aclk);
         ta   = s_axi_awvalid && s_axi_awready;
         tw   = s_axi_wvalid && s_axi_wready;
         done = s_axi_bvalid;
         rs   = s_axi_bresp;
         @(posedge aclk);
         s_axi_awvalid <= s_axi_awvalid && !ta;
         s_axi_wvalid  <= s_axi_wvalid && !tw;
         s_axi_bready  <= !done;
      end
   endtask : wr_reg

   task automatic rd_reg(input logic [3:0] a);
      logic done;
      logic ta;
      done = 1'b0;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      while (!done)
      begin
         @(negedge aclk);
         ta   = s_axi_arvalid && s_axi_arready;
         done = s_axi_rvalid;
         rd   = s_axi_rdata;
         rs   = s_axi_rresp;
         @(posedge aclk);
         s_axi_arvalid <= s_axi_arvalid && !ta;
         s_axi_rready  <= !done;
      end
   endtask : rd_reg

   task automatic count_ticks(output int t);
      t = 0;
      repeat (128)
      begin
         @(negedge aclk);
         t += sys_clock_tick;
      end
   endtask : count_ticks

   task automatic stop_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : stop_test

   initial
   begin
      #1_000_000;
      miscompares++;
      stop_test();
   end

   initial
   begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, halt_exec, wake_up} = 4'h0;
      watchdog_enabled = 1'b0;
      fast_rc_tick = 1'b1;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 12'h000;
      s_axi_wdata = 32'h0000_0000;
      miscompares = 0;
      comparisons = 0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      // reset values, ignored write, unmapped address
      rd_reg(clock_mode_pkg::mode_ctrl_offset);
      `check("ctrl_reset", 32'h0000_0003, rd & 32'h0000_00F7)
      wr_reg(clock_mode_pkg::mode_ctrl2_offset, 8'h80, 4'h0);
      rd_reg(clock_mode_pkg::mode_ctrl2_offset);
      `check("ctrl2_reset", 32'h0000_0000, rd)
      rd_reg(4'hC);
      `check("bad_rd", 34'h2_0000_0000, {rs, rd})
      wr_reg(4'hC, 8'hFF, 4'hF);
      `check("bad_wr", 2'h2, rs)
      repeat (20) @(posedge aclk);
      rd_reg(clock_mode_pkg::mode_ctrl_offset);
      `check("ready_up", 32'h0000_000C, rd & 32'h0000_000C)
      // clock select rows
      foreach (rows[i])
      begin
         wr_reg(clock_mode_pkg::mode_ctrl_offset, rows[i].ctrl, 4'hF);
         repeat (40) @(posedge aclk);
         on_slow = !rows[i].ctrl[0] && rows[i].ctrl[7:6] == 2'h0;
         count_ticks(ticks);
         `check("ticks", int'(rows[i].ticks), ticks)
         `check("mode", {2'h0, on_slow}, op_mode)
         `check("fast_en", !on_slow, fast_rc_enable)
         rd_reg(clock_mode_pkg::mode_ctrl_offset);
         `check("ctrl", {24'h00_0000, rows[i].ctrl | 8'h08 |
                (on_slow ? 8'h00 : 8'h04)}, rd)
      end
      // halt modes from the fast clock
      for (int i = 0; i < 4; i++)
      begin
         wr_reg(clock_mode_pkg::mode_ctrl_offset, {6'h00, i[1], 1'b1},
                4'hF);
         wr_reg(clock_mode_pkg::mode_ctrl2_offset, {i[0], 7'h00}, 4'hF);
         watchdog_enabled <= i[0];
         repeat (40) @(posedge aclk);
         want_mode = i[1] ? {2'h1, i[0]} : {2'h2, i[0]};
         halt_exec <= 1'b1;
         @(posedge aclk);
         halt_exec <= 1'b0;
         @(negedge aclk);
         `check("halt_mode", want_mode, op_mode)
         `check("pd_pulse", 1'b1, power_down_set)
         `check("cpu_en", 1'b0, cpu_clock_enable)
         count_ticks(ticks);
         `check("halt_ticks", (want_mode == 3'h3) ? 128 : 0, ticks)
         rd_reg(clock_mode_pkg::status_offset);
         `check("status", {2'h2, want_mode}, rd[4:0])
         rd_reg(clock_mode_pkg::mode_ctrl_offset);
         `check("slow_rdy", want_mode != 3'h4, rd[3])
         @(posedge aclk);
         wake_up <= 1'b1;
         @(posedge aclk);
         wake_up <= 1'b0;
         repeat (6) @(posedge aclk);
         rd_reg(clock_mode_pkg::mode_ctrl_offset);
         `check("wake_rdy", 1'b1, rd[3])
         `check("run", 3'h0, op_mode)
      end
      stop_test();
   end
endmodule : system_clock_mode_control_tb_top
